// ===== hw/fsdr_map.svh
/*
 * register map of the fail-safe diagnostic and status bank: offsets, field positions,
 * reset values and timing counts. assumes a 100 MHz ref_clk.
 */
`ifndef FSDR_MAP_SVH
`define FSDR_MAP_SVH
// ****************************************
// register indexes
// ****************************************
`define FSDR_ADDR_SAFE_IOS 6'h14
`define FSDR_ADDR_DIAG 6'h15
`define FSDR_ADDR_MASK 6'h16
`define FSDR_ADDR_STATES 6'h17
// ****************************************
// safe outputs control fields
// ****************************************
`define FSDR_IOS_PWR_SHORT 15
`define FSDR_IOS_PWR_EVT 14
`define FSDR_IOS_PWR_SNS 13
`define FSDR_IOS_RST_DRV 11
`define FSDR_IOS_RST_SNS 10
`define FSDR_IOS_INIT_REQ 2
`define FSDR_IOS_STBY 1
// ****************************************
// diagnostic flag fields
// ****************************************
`define FSDR_DIAG_PAIR 15
`define FSDR_DIAG_FA 14
`define FSDR_DIAG_FB 13
`define FSDR_DIAG_WDD 12
`define FSDR_DIAG_WDT 11
`define FSDR_DIAG_AB1 10
`define FSDR_DIAG_AB2 9
`define FSDR_DIAG_FAST 8
`define FSDR_DIAG_SLOW 7
`define FSDR_DIAG_CRC 6
`define FSDR_DIAG_ACC 5
`define FSDR_DIAG_LSKIP 4
`define FSDR_DIAG_LRAN 3
`define FSDR_DIAG_LPASS 2
// sticky write-1-clear bits of the diagnostic register
`define FSDR_DIAG_W1C_MASK 16'hf9e0
// ****************************************
// inhibit mask and states fields
// ****************************************
`define FSDR_MASK_WR_MASK 16'h03ff
`define FSDR_MASK_RESET 16'h0000
`define FSDR_ST_DBG_LEAVE 14
`define FSDR_ST_DBG_ACT 13
`define FSDR_ST_FUSE 11
`define FSDR_ST_INITREG 9
`define FSDR_CODE_INIT 5'h06
`define FSDR_CODE_WAIT2 5'h07
`define FSDR_CODE_RUN2 5'h08
// ****************************************
// timing
// ****************************************
`define FSDR_CLK_MHZ 100
`define FSDR_FUSE_CHECK_US 5000
`define FSDR_FUSE_CHECK_CYC (`FSDR_FUSE_CHECK_US * `FSDR_CLK_MHZ)
`endif

// ===== hw/fsdr_pkg.sv
/*
 * types of the fail-safe diagnostic bank. assumes fsdr_map.svh for numbers.
 */
`default_nettype none
package fsdr_pkg;
  typedef enum logic [4:0] {
    FSDR_ST_INIT = 5'h06,
    FSDR_ST_WAIT2 = 5'h07,
    FSDR_ST_RUN2 = 5'h08,
    FSDR_ST_NORMAL = 5'h09
  } fsdr_state_e;
  // bus access toward the register bank
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } fsdr_req_s;
  // hardware event pulses that set sticky flags
  typedef struct packed {
    logic pwr_short;
    logic pwr_evt;
    logic pair_err;
    logic fa_err;
    logic fb_err;
    logic wdog_data;
    logic wdog_timing;
    logic clk_fast;
    logic clk_slow;
    logic crc_err;
    logic fuse_crc_bad;
  } fsdr_evt_s;
  // live self-test status, already in this clock domain
  typedef struct packed {
    logic ab1_pass;
    logic ab2_pass;
    logic lb_skip;
    logic lb_ran;
    logic lb_pass;
    logic ab2_done;
  } fsdr_bist_s;
endpackage
`default_nettype wire

// ===== hw/fsdr_regs.sv
/*
 * fail-safe diagnostic and status register bank with fail-safe state code.
 * assumes a serial front end that hands over decoded 16-bit accesses one cycle wide,
 * events as one-cycle pulses on ref_clk, and pads that are asynchronous.
 */
// Behaviour
// - reset pad sense bit reads live reset pin level, not stored.
// - reset driver command bit reflects internal reset command in real time.
// - power-good short flag sets on short high, cleared by reset or write 1.
// - power-good event flag sets on event, cleared by reset or write 1.
// - power-good pad sense bit reports live pin level.
// - standby request bit: 1 requests standby, 0 none, resets to 0.
// - writing 1 to return-to-init sends state machine to init; 0 does nothing.
// - paired, input a and input b fault flags set on error, write-1 clear.
// - watchdog data error flag sets on wrong answer, write-1 clear.
// - watchdog timing error flag sets on wrong window or timeout, write-1 clear.
// - two analog self-test bits read 1 on pass; second 0 also means not run.
// - low-power clock too fast and too slow flags, write-1 clear.
// - bus crc error flag sets on failed crc, write-1 clear.
// - access violation flag sets on bad access, write-1 clear.
// - logic self-test skipped, ran and pass bits are read only.
// - inhibit bits mask irq for fault inputs, regulator, watchdog; reset 0.
// - one inhibit bit per voltage monitor masks both over and under events.
// - fuse config crc checked every 5ms; error sets flag, write-1 clear.
// - init registers compared with inverted shadow; mismatch sets flag, write-1 clear.
// - 5-bit state code: 00110 init, 00111 wait second test, 01000 running it.
`include "fsdr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module fsdr_regs #(
  parameter int unsigned FUSE_CHECK_CYC = `FSDR_FUSE_CHECK_CYC,
  parameter int unsigned NUM_INIT_REGS = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire fsdr_pkg::fsdr_req_s bus_req,
  input wire logic bad_access,
  input wire fsdr_pkg::fsdr_evt_s evt,
  input wire fsdr_pkg::fsdr_bist_s bist,
  input wire logic reset_pad,
  input wire logic pwr_ok_pad,
  input wire logic reset_cmd,
  input wire logic debug_entry,
  input wire logic [NUM_INIT_REGS*16-1:0] init_regs,
  input wire logic [NUM_INIT_REGS*16-1:0] init_regs_inv,
  input wire logic [9:0] mon_irq_src,
  output logic [15:0] rdata,
  output logic irq_out,
  output logic standby_request,
  output logic fuse_check_req,
  output logic [4:0] safety_state_code
);
  import fsdr_pkg::*;

  // ****************************************
  // pad synchronisers
  // ****************************************
  logic [1:0] rst_pad_q;
  logic [1:0] pwr_pad_q;
  // two stages; only the second stage feeds logic
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_pad_q <= 2'b00;
      pwr_pad_q <= 2'b00;
    end else if (clk_en) begin
      rst_pad_q <= {rst_pad_q[0], reset_pad};
      pwr_pad_q <= {pwr_pad_q[0], pwr_ok_pad};
    end
  end

  // ****************************************
  // write strobes
  // ****************************************
  logic wr_ios;
  logic wr_diag;
  logic wr_mask;
  logic wr_st;
  // address decode
  always_comb begin
    wr_ios = 1'b0;
    wr_diag = 1'b0;
    wr_mask = 1'b0;
    wr_st = 1'b0;
    if (bus_req.wr && bus_req.addr == `FSDR_ADDR_SAFE_IOS) begin
      wr_ios = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `FSDR_ADDR_DIAG) begin
      wr_diag = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `FSDR_ADDR_MASK) begin
      wr_mask = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `FSDR_ADDR_STATES) begin
      wr_st = 1'b1;
    end
  end

  // ****************************************
  // sticky flags
  // ****************************************
  logic pwr_short_q, pwr_evt_q;
  logic [15:0] diag_q;
  logic fuse_q, initreg_q;
  logic [15:0] diag_set;
  logic [15:0] diag_clr;
  logic mismatch;
  assign mismatch = (init_regs ^ init_regs_inv) != {NUM_INIT_REGS*16{1'b1}};
  always_comb begin
    diag_set = 16'h0000;
    diag_set[`FSDR_DIAG_PAIR] = evt.pair_err;
    diag_set[`FSDR_DIAG_FA] = evt.fa_err;
    diag_set[`FSDR_DIAG_FB] = evt.fb_err;
    diag_set[`FSDR_DIAG_WDD] = evt.wdog_data;
    diag_set[`FSDR_DIAG_WDT] = evt.wdog_timing;
    diag_set[`FSDR_DIAG_FAST] = evt.clk_fast;
    diag_set[`FSDR_DIAG_SLOW] = evt.clk_slow;
    diag_set[`FSDR_DIAG_CRC] = evt.crc_err;
    diag_set[`FSDR_DIAG_ACC] = bad_access;
    diag_clr = wr_diag ? (bus_req.wdata & `FSDR_DIAG_W1C_MASK) : 16'h0000;
  end
  // set wins over a same-cycle write-1 clear so no event is lost
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      diag_q <= 16'h0000;
      pwr_short_q <= 1'b0;
      pwr_evt_q <= 1'b0;
      fuse_q <= 1'b0;
      initreg_q <= 1'b0;
    end else if (clk_en) begin
      diag_q <= (diag_q & ~diag_clr) | diag_set;
      pwr_short_q <= evt.pwr_short | (pwr_short_q &
        ~(wr_ios & bus_req.wdata[`FSDR_IOS_PWR_SHORT]));
      pwr_evt_q <= evt.pwr_evt | (pwr_evt_q &
        ~(wr_ios & bus_req.wdata[`FSDR_IOS_PWR_EVT]));
      fuse_q <= evt.fuse_crc_bad | (fuse_q & ~(wr_st & bus_req.wdata[`FSDR_ST_FUSE]));
      initreg_q <= mismatch | (initreg_q & ~(wr_st & bus_req.wdata[`FSDR_ST_INITREG]));
    end
  end

  // ****************************************
  // control bits
  // ****************************************
  logic [9:0] mask_q;
  logic stby_q, dbg_q;
  // inhibit mask and standby request are plain stored bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= 10'h000;
      stby_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_mask) begin
        mask_q <= bus_req.wdata[9:0];
      end
      if (wr_ios) begin
        stby_q <= bus_req.wdata[`FSDR_IOS_STBY];
      end
    end
  end
  // debug mode: entry beats a same-cycle leave, as set beats clear everywhere
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dbg_q <= 1'b0;
    end else if (clk_en) begin
      if (debug_entry) begin
        dbg_q <= 1'b1;
      end else if (wr_st && bus_req.wdata[`FSDR_ST_DBG_LEAVE]) begin
        dbg_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // fuse crc period
  // ****************************************
  logic [31:0] fuse_cnt_q;
  logic fuse_req_q;
  // one request pulse every check period
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fuse_cnt_q <= 32'h00000000;
      fuse_req_q <= 1'b0;
    end else if (clk_en) begin
      fuse_req_q <= 1'b0;
      if (fuse_cnt_q == FUSE_CHECK_CYC - 1) begin
        fuse_cnt_q <= 32'h00000000;
        fuse_req_q <= 1'b1;
      end else begin
        fuse_cnt_q <= fuse_cnt_q + 32'h00000001;
      end
    end
  end

  // ****************************************
  // fail-safe state machine
  // ****************************************
  fsdr_state_e st_q;
  // return-to-init beats normal progress
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= FSDR_ST_INIT;
    end else if (clk_en) begin
      if (wr_ios && bus_req.wdata[`FSDR_IOS_INIT_REQ]) begin
        st_q <= FSDR_ST_INIT;
      end else begin
        case (st_q)
          FSDR_ST_INIT: st_q <= FSDR_ST_WAIT2;
          FSDR_ST_WAIT2: st_q <= FSDR_ST_RUN2;
          FSDR_ST_RUN2: begin
            if (bist.ab2_done) begin
              st_q <= FSDR_ST_NORMAL;
            end
          end
          default: st_q <= st_q;
        endcase
      end
    end
  end

  // ****************************************
  // read data and outputs
  // ****************************************
  logic [15:0] rd_d;
  always_comb begin
    rd_d = 16'h0000;
    if (bus_req.addr == `FSDR_ADDR_SAFE_IOS) begin
      rd_d[`FSDR_IOS_PWR_SHORT] = pwr_short_q;
      rd_d[`FSDR_IOS_PWR_EVT] = pwr_evt_q;
      rd_d[`FSDR_IOS_PWR_SNS] = pwr_pad_q[1];
      rd_d[`FSDR_IOS_RST_DRV] = reset_cmd;
      rd_d[`FSDR_IOS_RST_SNS] = rst_pad_q[1];
    end else if (bus_req.addr == `FSDR_ADDR_DIAG) begin
      rd_d = diag_q;
      rd_d[`FSDR_DIAG_AB1] = bist.ab1_pass;
      rd_d[`FSDR_DIAG_AB2] = bist.ab2_pass;
      rd_d[`FSDR_DIAG_LSKIP] = bist.lb_skip;
      rd_d[`FSDR_DIAG_LRAN] = bist.lb_ran;
      rd_d[`FSDR_DIAG_LPASS] = bist.lb_pass;
    end else if (bus_req.addr == `FSDR_ADDR_MASK) begin
      rd_d = {6'h00, mask_q};
    end else if (bus_req.addr == `FSDR_ADDR_STATES) begin
      rd_d[`FSDR_ST_DBG_ACT] = dbg_q;
      rd_d[`FSDR_ST_FUSE] = fuse_q;
      rd_d[`FSDR_ST_INITREG] = initreg_q;
      rd_d[4:0] = st_q;
    end
  end
  // registered outputs; read data valid the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
      irq_out <= 1'b0;
      standby_request <= 1'b0;
      fuse_check_req <= 1'b0;
      safety_state_code <= `FSDR_CODE_INIT;
    end else if (clk_en) begin
      if (bus_req.rd) begin
        rdata <= rd_d;
      end
      irq_out <= |(mon_irq_src & ~mask_q);
      standby_request <= stby_q;
      fuse_check_req <= fuse_req_q;
      safety_state_code <= st_q;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_init_return: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && wr_ios && bus_req.wdata[`FSDR_IOS_INIT_REQ] |=> st_q == FSDR_ST_INIT)
    else $error("return to init ignored");
  a_wdog_data_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && evt.wdog_data |=> diag_q[`FSDR_DIAG_WDD])
    else $error("watchdog data flag lost");
  a_pwr_short_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && evt.pwr_short |=> pwr_short_q)
    else $error("short flag lost");
  a_pwr_evt_clr: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && wr_ios && bus_req.wdata[`FSDR_IOS_PWR_EVT] && !evt.pwr_evt |=> !pwr_evt_q)
    else $error("event flag not cleared");
  // each fault flag checked against its own pulse, so a swapped bit is caught
  a_fault_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && (evt.pair_err || evt.fa_err || evt.fb_err) |=>
      (diag_q[`FSDR_DIAG_PAIR] || !$past(evt.pair_err)) &&
      (diag_q[`FSDR_DIAG_FA] || !$past(evt.fa_err)) &&
      (diag_q[`FSDR_DIAG_FB] || !$past(evt.fb_err)))
    else $error("fault flag lost");
  a_crc_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && evt.crc_err |=> diag_q[`FSDR_DIAG_CRC])
    else $error("crc flag lost");
  a_access_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && bad_access |=> diag_q[`FSDR_DIAG_ACC])
    else $error("access flag lost");
  a_debug_leave: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && wr_st && bus_req.wdata[`FSDR_ST_DBG_LEAVE] && !debug_entry |=> !dbg_q)
    else $error("debug not left");
  a_irq_masked: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && (mon_irq_src & ~mask_q) == 10'h000 |=> !irq_out)
    else $error("masked source raised irq");
  a_state_seq: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && st_q == FSDR_ST_INIT && !wr_ios |=> st_q == FSDR_ST_WAIT2)
    else $error("state sequence broken");
  c_init_back: cover property (@(posedge ref_clk) disable iff (!nrst)
    st_q == FSDR_ST_NORMAL ##1 st_q == FSDR_ST_INIT);
  c_irq: cover property (@(posedge ref_clk) disable iff (!nrst) irq_out);
  c_mismatch: cover property (@(posedge ref_clk) disable iff (!nrst) initreg_q);
endmodule
`default_nettype wire

// ===== verif/fsdr_mcu.sv
/*
 * partner model of the controller that reaches the fail-safe bank over its decoded bus.
 * assumes one clock, accesses raised just after an edge and taken on the next one.
 */
`timescale 1ns/100ps
`default_nettype none
module fsdr_mcu (
  input wire logic ref_clk,
  input wire logic [15:0] rdata,
  output var fsdr_pkg::fsdr_req_s bus_req
);
  import fsdr_pkg::*;
  // ****************************************
  // bus access tasks
  // ****************************************
  // idle bus from time zero, so nothing is taken before the first call
  initial begin
    bus_req = '0;
  end
  // one-cycle write; standby is requested by writing its bit as 1
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  // one-cycle read; data is taken after the answering edge has landed
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
    #1 v = rdata;
  endtask
endmodule
`default_nettype wire

// ===== verif/fsdr_tb.sv
/*
 * self-checking bench of the fail-safe diagnostic bank, driven through the partner model.
 * assumes fsdr_map.svh and fsdr_pkg, and a short fuse check period for simulation.
 */
`include "fsdr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fsdr_pkg::*;
  logic ref_clk, nrst, clk_en, bad_access, reset_pad, pwr_ok_pad, reset_cmd, debug_entry;
  logic irq_out, standby_request, fuse_check_req;
  logic [15:0] rdata, d;
  logic [63:0] init_regs, init_regs_inv;
  logic [9:0] mon_irq_src;
  logic [4:0] safety_state_code;
  fsdr_req_s bus_req;
  fsdr_evt_s evt;
  fsdr_bist_s bist;
  int errors, comparisons, n;
  // sticky sources, msb of evt first, access violation last
  logic [5:0] ev_addr [0:11] = '{6'h14, 6'h14, 6'h15, 6'h15, 6'h15, 6'h15, 6'h15, 6'h15,
    6'h15, 6'h15, 6'h17, 6'h15};
  int ev_bit [0:11] = '{15, 14, 15, 14, 13, 12, 11, 8, 7, 6, 11, 5};
  // ****************************************
  // instances and clock
  // ****************************************
  fsdr_regs #(.FUSE_CHECK_CYC(20), .NUM_INIT_REGS(4)) fsdr_regs_inst (.ref_clk(ref_clk),
    .nrst(nrst), .clk_en(clk_en), .bus_req(bus_req), .bad_access(bad_access), .evt(evt),
    .bist(bist), .reset_pad(reset_pad), .pwr_ok_pad(pwr_ok_pad), .reset_cmd(reset_cmd),
    .debug_entry(debug_entry), .init_regs(init_regs), .init_regs_inv(init_regs_inv),
    .mon_irq_src(mon_irq_src), .rdata(rdata), .irq_out(irq_out),
    .standby_request(standby_request), .fuse_check_req(fuse_check_req),
    .safety_state_code(safety_state_code));
  fsdr_mcu fsdr_mcu_inst (.ref_clk(ref_clk), .rdata(rdata), .bus_req(bus_req));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // bounded wait for a state code, sampled once per cycle
  task automatic wait_code(input logic [4:0] c);
    n = 0;
    while (safety_state_code !== c && n < 8) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(16'(safety_state_code), 16'(c));
  endtask
  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("Error %0t: watchdog expired", $time);
    test_done();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    bad_access = 1'b0;
    evt = '0;
    bist = '0;
    reset_pad = 1'b0;
    pwr_ok_pad = 1'b0;
    reset_cmd = 1'b0;
    debug_entry = 1'b0;
    mon_irq_src = '0;
    init_regs = 64'h0123456789abcdef;
    init_regs_inv = ~64'h0123456789abcdef;
    repeat (2) @(posedge ref_clk);
    chk(16'(safety_state_code), 16'(`FSDR_CODE_INIT));
    nrst <= 1'b1;
    wait_code(`FSDR_CODE_WAIT2);
    wait_code(`FSDR_CODE_RUN2);
    // reset values, unmapped index reads zero
    for (int a = 0; a < 5; a++) begin
      fsdr_mcu_inst.rd((a == 4) ? 6'h00 : 6'(`FSDR_ADDR_SAFE_IOS + a), d);
      chk(d, (a == 3) ? 16'(`FSDR_CODE_RUN2) : 16'h0000);
    end
    // live pad and command levels in both polarities
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      reset_pad <= (k == 0);
      reset_cmd <= (k == 0);
      pwr_ok_pad <= (k == 1);
      repeat (4) @(posedge ref_clk);
      fsdr_mcu_inst.rd(`FSDR_ADDR_SAFE_IOS, d);
      chk(16'(d[`FSDR_IOS_RST_SNS]), 16'(k == 0));
      chk(16'(d[`FSDR_IOS_RST_DRV]), 16'(k == 0));
      chk(16'(d[`FSDR_IOS_PWR_SNS]), 16'(k == 1));
    end
    // every sticky flag but the init register mismatch: set by its pulse, cleared by a write of 1
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      if (i < 11)
        evt <= fsdr_evt_s'(11'h1 << (10 - i));
      else
        bad_access <= 1'b1;
      @(posedge ref_clk);
      evt <= '0;
      bad_access <= 1'b0;
      fsdr_mcu_inst.rd(ev_addr[i], d);
      chk(16'(d[ev_bit[i]]), 16'h0001);
      fsdr_mcu_inst.wr(ev_addr[i], 16'h1 << ev_bit[i]);
      fsdr_mcu_inst.rd(ev_addr[i], d);
      chk(16'(d[ev_bit[i]]), 16'h0000);
    end
    // self-test bits are live and ignore writes
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      bist <= fsdr_bist_s'((k == 0) ? 6'b101010 : 6'b010100);
      fsdr_mcu_inst.wr(`FSDR_ADDR_DIAG, 16'hffff);
      fsdr_mcu_inst.rd(`FSDR_ADDR_DIAG, d);
      chk(d & 16'h061c, (k == 0) ? 16'h0414 : 16'h0208);
    end
    // inhibit bits: writable width, then each source masked alone
    fsdr_mcu_inst.wr(`FSDR_ADDR_MASK, 16'hffff);
    fsdr_mcu_inst.rd(`FSDR_ADDR_MASK, d);
    chk(d, `FSDR_MASK_WR_MASK);
    fsdr_mcu_inst.wr(`FSDR_ADDR_MASK, `FSDR_MASK_RESET);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      mon_irq_src <= 10'h1 << i;
      repeat (3) @(posedge ref_clk);
      #1 chk(16'(irq_out), 16'h0001);
      fsdr_mcu_inst.wr(`FSDR_ADDR_MASK, 16'h1 << i);
      repeat (3) @(posedge ref_clk);
      #1 chk(16'(irq_out), 16'h0000);
      fsdr_mcu_inst.wr(`FSDR_ADDR_MASK, `FSDR_MASK_RESET);
      mon_irq_src <= '0;
    end
    // standby request follows the written bit
    for (int k = 1; k >= 0; k--) begin
      fsdr_mcu_inst.wr(`FSDR_ADDR_SAFE_IOS, 16'(k) << `FSDR_IOS_STBY);
      repeat (3) @(posedge ref_clk);
      #1 chk(16'(standby_request), 16'(k));
    end
    // return to init: 0 leaves the machine alone, 1 sends it back
    @(posedge ref_clk);
    bist <= fsdr_bist_s'(6'b000001);
    wait_code(FSDR_ST_NORMAL);
    fsdr_mcu_inst.wr(`FSDR_ADDR_SAFE_IOS, 16'h0000);
    repeat (3) @(posedge ref_clk);
    #1 chk(16'(safety_state_code), 16'(FSDR_ST_NORMAL));
    fsdr_mcu_inst.wr(`FSDR_ADDR_SAFE_IOS, 16'h1 << `FSDR_IOS_INIT_REQ);
    wait_code(`FSDR_CODE_INIT);
    // debug entry, then leave by writing 1
    @(posedge ref_clk);
    debug_entry <= 1'b1;
    @(posedge ref_clk);
    debug_entry <= 1'b0;
    fsdr_mcu_inst.rd(`FSDR_ADDR_STATES, d);
    chk(16'(d[`FSDR_ST_DBG_ACT]), 16'h0001);
    fsdr_mcu_inst.wr(`FSDR_ADDR_STATES, 16'h1 << `FSDR_ST_DBG_LEAVE);
    fsdr_mcu_inst.rd(`FSDR_ADDR_STATES, d);
    chk(16'(d[`FSDR_ST_DBG_ACT]), 16'h0000);
    // one corrupted shadow bit, then repaired and cleared
    @(posedge ref_clk);
    init_regs_inv <= ~init_regs ^ 64'h20;
    repeat (3) @(posedge ref_clk);
    fsdr_mcu_inst.rd(`FSDR_ADDR_STATES, d);
    chk(16'(d[`FSDR_ST_INITREG]), 16'h0001);
    @(posedge ref_clk);
    init_regs_inv <= ~init_regs;
    repeat (3) @(posedge ref_clk);
    fsdr_mcu_inst.wr(`FSDR_ADDR_STATES, 16'h1 << `FSDR_ST_INITREG);
    fsdr_mcu_inst.rd(`FSDR_ADDR_STATES, d);
    chk(16'(d[`FSDR_ST_INITREG]), 16'h0000);
    // enable low: a pulse and a return request are both lost
    @(posedge ref_clk);
    clk_en <= 1'b0;
    evt.crc_err <= 1'b1;
    fsdr_mcu_inst.wr(`FSDR_ADDR_SAFE_IOS, 16'h1 << `FSDR_IOS_INIT_REQ);
    evt.crc_err <= 1'b0;
    clk_en <= 1'b1;
    fsdr_mcu_inst.rd(`FSDR_ADDR_DIAG, d);
    chk(16'(d[`FSDR_DIAG_CRC]), 16'h0000);
    chk(16'(safety_state_code), 16'(FSDR_ST_NORMAL));
    // mid-run reset clears a sticky flag and restarts the state code
    @(posedge ref_clk);
    evt.wdog_timing <= 1'b1;
    @(posedge ref_clk);
    evt.wdog_timing <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(16'(safety_state_code), 16'(`FSDR_CODE_INIT));
    nrst <= 1'b1;
    fsdr_mcu_inst.rd(`FSDR_ADDR_DIAG, d);
    chk(16'(d[`FSDR_DIAG_WDT]), 16'h0000);
    // fuse check pacing: spacing between two requests
    n = 0;
    while (fuse_check_req !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (fuse_check_req !== 1'b1 && n < 40);
    chk(16'(n), 16'd20);
    test_done();
  end
endmodule
`default_nettype wire
